// ==== uart_baud_gen.sv ====
`timescale 1ns/100ps
// Divides the source clock enable by count+1; restart realigns phase.
module uart_baud_gen #(
    parameter int COUNT_WIDTH = uart_engine_pkg::BAUD_COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic src_tick,
    input wire logic restart,
    input wire logic [COUNT_WIDTH-1:0] count_value,
    input wire logic [COUNT_WIDTH-1:0] rise_point,
    output logic fall_tick,
    output logic rise_tick
);
    logic [COUNT_WIDTH-1:0] cnt_ff;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= '0;
        end else if (restart) begin
            cnt_ff <= '0;
        end else if (src_tick) begin
            cnt_ff <= (cnt_ff >= count_value) ? '0 : cnt_ff + 1'b1;
        end
    end

    assign fall_tick = src_tick && !restart && (cnt_ff >= count_value);
    assign rise_tick = src_tick && !restart && (cnt_ff == rise_point);
endmodule // uart_baud_gen

// ==== uart_engine_checker.sv ====
`timescale 1ns/100ps
module uart_engine_checker #(
    parameter int COUNT_WIDTH = uart_engine_pkg::BAUD_COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_in_pin_b,
    input wire logic serial_out_pin,
    input wire logic channel_irq
);
    localparam logic [2:0] ST = uart_engine_pkg::ADDR_STATUS;
    localparam logic [2:0] BF = uart_engine_pkg::ADDR_BUFFER;
    logic rx_ff;
    logic ran_ff;
    logic [8:0] quiet_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Software view of direction and of run ever set; cycles since the line was low
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_ff <= 1'b0;
        end else if (reg_write && reg_addr == uart_engine_pkg::ADDR_MODE0) begin
            rx_ff <= reg_wdata[uart_engine_pkg::MODE0_DIR_BIT];
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ran_ff <= 1'b0;
        end else if (reg_write && reg_addr == uart_engine_pkg::ADDR_CONTROL) begin
            ran_ff <= ran_ff | reg_wdata[uart_engine_pkg::CTRL_RUN_BIT];
        end
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            quiet_ff <= 9'h1ff;
        end else if (!serial_in_pin_b) begin
            quiet_ff <= 9'h000;
        end else if (quiet_ff != 9'h1ff) begin
            quiet_ff <= quiet_ff + 9'h001;
        end
    end
    property p_irq_pulse;
        channel_irq |=> !channel_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt pulse longer than one cycle");
    property p_idle_before_run;
        !ran_ff |-> serial_out_pin && !channel_irq;
    endproperty
    a_idle_before_run: assert property (p_idle_before_run)
        else $error("activity before run was ever set");
    property p_full_set;
        (reg_write && reg_addr == BF && !rx_ff) ##2 (reg_read && reg_addr == ST)
            |=> reg_rdata[uart_engine_pkg::STAT_FUL_BIT];
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("full flag not set by buffer write");
    property p_stat_clear;
        (reg_write && reg_addr == ST && !channel_irq) ##1 !channel_irq
            ##1 (reg_read && reg_addr == ST && !channel_irq) |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear)
        else $error("status write left a flag set");
    property p_tx_no_err;
        !rx_ff && reg_read && reg_addr == ST |=> reg_rdata[2:0] == 3'h0;
    endproperty
    a_tx_no_err: assert property (p_tx_no_err)
        else $error("error flag seen in transmit mode");
    property p_rx_no_full;
        rx_ff && reg_read && reg_addr == ST |=> !reg_rdata[uart_engine_pkg::STAT_FUL_BIT];
    endproperty
    a_rx_no_full: assert property (p_rx_no_full)
        else $error("full flag seen in receive mode");
    property p_rx_out_high;
        rx_ff && $past(rx_ff) |-> serial_out_pin;
    endproperty
    a_rx_out_high: assert property (p_rx_out_high)
        else $error("output not high in receive mode");
    property p_rx_irq_cause;
        rx_ff && channel_irq |-> quiet_ff < 9'd200;
    endproperty
    a_rx_irq_cause: assert property (p_rx_irq_cause)
        else $error("receive interrupt without a recent frame");
endmodule // uart_engine_checker

bind uart_tx_rx_engine uart_engine_checker #(.COUNT_WIDTH(COUNT_WIDTH)) chk_u (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .serial_in_pin_b(serial_in_pin_b),
    .serial_out_pin(serial_out_pin),
    .channel_irq(channel_irq)
);

// ==== uart_engine_pkg.sv ====
package uart_engine_pkg;
    // Register indices on the plain register port
    localparam logic [2:0] ADDR_MODE0 = 3'h0;
    localparam logic [2:0] ADDR_FORMAT = 3'h1;
    localparam logic [2:0] ADDR_BAUD_LOW = 3'h2;
    localparam logic [2:0] ADDR_BAUD_HIGH = 3'h3;
    localparam logic [2:0] ADDR_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_BUFFER = 3'h5;
    localparam logic [2:0] ADDR_STATUS = 3'h6;
    // mode_config_zero fields
    localparam int MODE0_DIR_BIT = 0;
    localparam int MODE0_CLKSEL_LO = 1;
    localparam int MODE0_RSEL_BIT = 4;
    localparam int MODE0_RSS_BIT = 5;
    // frame_format_config fields
    localparam int FMT_LEN_LO = 0;
    localparam int FMT_PAR_EN_BIT = 2;
    localparam int FMT_PAR_ODD_BIT = 3;
    localparam int FMT_STOP2_BIT = 4;
    localparam int FMT_MSB_BIT = 5;
    localparam int FMT_NEG_BIT = 6;
    // channel_control_reg / channel_status_reg fields
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_FER_BIT = 0;
    localparam int STAT_OER_BIT = 1;
    localparam int STAT_PER_BIT = 2;
    localparam int STAT_FUL_BIT = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int BAUD_COUNT_WIDTH = 12;
    localparam int DATA_LEN_MIN = 5;
endpackage

// ==== uart_parity_calc.sv ====
`timescale 1ns/100ps
// Parity over the low len+5 bits of a byte.
module uart_parity_calc (
    input wire logic [7:0] data,
    input wire logic [1:0] len_code,
    input wire logic odd_sense,
    output logic parity
);
    logic [7:0] mask;

    always_comb begin
        mask = 8'hff >> (2'd3 - len_code);
        parity = (^(data & mask)) ^ odd_sense;
    end
endmodule // uart_parity_calc

// ==== uart_peer_model.sv ====
`timescale 1ns/100ps
module uart_peer_model #(
    parameter int BIT = 16
) (
    input wire logic ref_clk,
    input wire logic serial_out_pin,
    output logic serial_in_pin_b
);
    logic [7:0] got_q[$];
    logic [7:0] cap;
    initial serial_in_pin_b = 1'b1;
    // Start, eight data bits LSB first, parity, one stop; then pulled high
    task automatic send(input logic [7:0] d, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_in_pin_b <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
        serial_in_pin_b <= 1'b1;
    endtask
    // Mid-bit capture of frames leaving the block
    initial begin
        forever begin
            @(negedge serial_out_pin);
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge ref_clk);
                cap[i] = serial_out_pin;
            end
            repeat (BIT) @(posedge ref_clk);
            if (serial_out_pin === 1'b1) got_q.push_back(cap);
        end
    end
endmodule // uart_peer_model

// ==== uart_tx_rx_engine.sv ====
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Transmit starts with direction zero, run set
// - Run bit starts baud clock and transmitter
// - Start, data, parity, stop on falling edges
// - Interrupt when each start bit goes out
// - Buffer write sets full; sent next frame
// - No new byte: finish, clear run, interrupt
// - Receive needs pin select, direction one, run
// - Start detection realigns the transfer clock
// - Rising edges shift in data and parity
// - Received word moved to buffer at the stop-bit rise
// - Same stop-bit rise: interrupt, stop and parity checks
// - Errors set parity, overrun, framing flags
// - Rising edge near centre of each bit
// - Reception runs until software clears run
// - Start sampled on source clock, one-tick lag
// - Sample shift bit moves point one tick
// - Any status write clears all flags; a received word completing in the same cycle loads the error flags instead
// - Length 5-8, parity, stops, order, polarity
// - Baud divides source by count plus one
// - Overrun when unread byte gets replaced
module uart_tx_rx_engine #(
    parameter int COUNT_WIDTH = uart_engine_pkg::BAUD_COUNT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] source_ticks,
    input wire logic serial_in_pin_a,
    input wire logic serial_in_pin_b,
    output logic serial_out_pin,
    output logic channel_irq
);
    typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} frame_state_t;

    logic [7:0] mode_config_zero_ff;
    logic [7:0] frame_format_config_ff;
    logic [7:0] baud_count_low_ff;
    logic [3:0] baud_count_high_ff;
    logic run_bit_ff;
    logic [7:0] shared_data_buffer_ff;
    logic buffer_full_flag_ff;
    logic parity_error_flag_ff;
    logic overrun_error_flag_ff;
    logic framing_error_flag_ff;
    logic rx_unread_ff;
    logic [7:0] reg_rdata_ff;
    logic [1:0] sync_a_ff;
    logic [1:0] sync_b_ff;
    logic [3:0] tick_meta_ff;
    logic [3:0] tick_sync_ff;
    logic [3:0] tick_prev_ff;
    frame_state_t state_ff;
    logic [2:0] bit_cnt_ff;
    logic stop_cnt_ff;
    logic [7:0] shift_ff;
    logic rx_parity_ff;
    logic serial_out_ff;
    logic irq_ff;
    logic rx_done_ff;
    logic run_prev_ff;

    logic transmit_mode;
    logic [1:0] len_code;
    logic [2:0] last_bit;
    logic src_tick;
    logic [1:0] clk_sel;
    logic fall_tick;
    logic rise_tick;
    logic restart;
    logic rx_level;
    logic start_seen;
    logic [COUNT_WIDTH-1:0] count_value;
    logic [COUNT_WIDTH-1:0] rise_point;
    logic tx_parity;
    logic rx_calc_parity;
    logic [7:0] rx_word;
    logic tx_bit;
    logic buf_load;
    logic stat_clear;

    assign transmit_mode = !mode_config_zero_ff[uart_engine_pkg::MODE0_DIR_BIT];
    assign len_code = frame_format_config_ff[uart_engine_pkg::FMT_LEN_LO +: 2];
    assign last_bit = 3'(uart_engine_pkg::DATA_LEN_MIN - 1) + 3'(len_code);
    assign count_value = COUNT_WIDTH'({baud_count_high_ff, baud_count_low_ff});
    assign clk_sel = mode_config_zero_ff[uart_engine_pkg::MODE0_CLKSEL_LO +: 2];
    // Half period, moved one source tick later by the shift bit
    assign rise_point = (count_value >> 1)
        + COUNT_WIDTH'(mode_config_zero_ff[uart_engine_pkg::MODE0_RSS_BIT]);
    assign stat_clear = reg_write && reg_addr == uart_engine_pkg::ADDR_STATUS;

    // Source clock enables arrive asynchronously; two stages, then edge detect
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick_meta_ff <= '0;
            tick_sync_ff <= '0;
            tick_prev_ff <= '0;
        end else begin
            tick_meta_ff <= source_ticks;
            tick_sync_ff <= tick_meta_ff;
            tick_prev_ff <= tick_sync_ff;
        end
    end
    assign src_tick = tick_sync_ff[clk_sel] && !tick_prev_ff[clk_sel];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync_a_ff <= 2'h3;
            sync_b_ff <= 2'h3;
        end else begin
            sync_a_ff <= {sync_a_ff[0], serial_in_pin_a};
            sync_b_ff <= {sync_b_ff[0], serial_in_pin_b};
        end
    end

    // Pin choice and polarity
    assign rx_level = (mode_config_zero_ff[uart_engine_pkg::MODE0_RSEL_BIT] ? sync_b_ff[1]
        : sync_a_ff[1]) ^ frame_format_config_ff[uart_engine_pkg::FMT_NEG_BIT];
    // Low level seen only on a source tick
    assign start_seen = !transmit_mode && state_ff == ST_IDLE && run_bit_ff
        && src_tick && !rx_level;
    assign restart = start_seen || (run_bit_ff && !run_prev_ff && transmit_mode);

    uart_baud_gen #(.COUNT_WIDTH(COUNT_WIDTH)) baud_gen_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .src_tick(src_tick),
        .restart(restart),
        .count_value(count_value),
        .rise_point(rise_point),
        .fall_tick(fall_tick),
        .rise_tick(rise_tick)
    );

    uart_parity_calc tx_par_i (
        .data(shared_data_buffer_ff),
        .len_code(len_code),
        .odd_sense(frame_format_config_ff[uart_engine_pkg::FMT_PAR_ODD_BIT]),
        .parity(tx_parity)
    );

    // Align received word to bit 0 for any length and order
    always_comb begin
        rx_word = frame_format_config_ff[uart_engine_pkg::FMT_MSB_BIT] ? shift_ff
            : shift_ff >> (2'd3 - len_code);
    end

    uart_parity_calc rx_par_i (
        .data(rx_word),
        .len_code(len_code),
        .odd_sense(frame_format_config_ff[uart_engine_pkg::FMT_PAR_ODD_BIT]),
        .parity(rx_calc_parity)
    );

    // Outgoing data bit by order
    always_comb begin
        tx_bit = frame_format_config_ff[uart_engine_pkg::FMT_MSB_BIT]
            ? shift_ff[3'(last_bit - bit_cnt_ff)] : shift_ff[bit_cnt_ff];
    end

    // Transmit buffer is taken into the shifter at each start bit
    assign buf_load = transmit_mode && fall_tick && run_bit_ff
        && (state_ff == ST_IDLE
        || (state_ff == ST_STOP && stop_cnt_ff && buffer_full_flag_ff));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= '0;
            stop_cnt_ff <= 1'b0;
            shift_ff <= uart_engine_pkg::RESET_BYTE;
            rx_parity_ff <= 1'b0;
            serial_out_ff <= 1'b1;
            rx_done_ff <= 1'b0;
        end else if (!run_bit_ff) begin
            state_ff <= ST_IDLE;
            serial_out_ff <= 1'b1;
            rx_done_ff <= 1'b0;
        end else if (transmit_mode) begin
            rx_done_ff <= 1'b0;
            if (fall_tick) begin
                unique case (state_ff)
                    ST_IDLE: begin
                        shift_ff <= shared_data_buffer_ff;
                        rx_parity_ff <= tx_parity;
                        bit_cnt_ff <= '0;
                        serial_out_ff <= 1'b0;
                        state_ff <= ST_START;
                    end
                    ST_START: begin
                        serial_out_ff <= tx_bit;
                        bit_cnt_ff <= 3'h1;
                        state_ff <= ST_DATA;
                    end
                    ST_DATA: begin
                        // Count wraps to zero after the eighth bit
                        if (bit_cnt_ff == 3'(last_bit + 3'h1)) begin
                            serial_out_ff <= frame_format_config_ff[uart_engine_pkg::FMT_PAR_EN_BIT]
                                ? rx_parity_ff : 1'b1;
                            stop_cnt_ff <= !frame_format_config_ff[uart_engine_pkg::FMT_STOP2_BIT];
                            state_ff <= frame_format_config_ff[uart_engine_pkg::FMT_PAR_EN_BIT]
                                ? ST_PARITY : ST_STOP;
                        end else begin
                            serial_out_ff <= tx_bit;
                            bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        end
                    end
                    ST_PARITY: begin
                        serial_out_ff <= 1'b1;
                        state_ff <= ST_STOP;
                    end
                    ST_STOP: begin
                        if (!stop_cnt_ff) begin
                            stop_cnt_ff <= 1'b1;
                        end else if (buffer_full_flag_ff) begin
                            shift_ff <= shared_data_buffer_ff;
                            bit_cnt_ff <= '0;
                            rx_parity_ff <= tx_parity;
                            serial_out_ff <= 1'b0;
                            state_ff <= ST_START;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                endcase
            end
        end else begin
            // Receive: shift on rise, word complete on the stop-bit rise
            serial_out_ff <= 1'b1;
            rx_done_ff <= 1'b0;
            if (start_seen) begin
                state_ff <= ST_START;
                bit_cnt_ff <= '0;
                shift_ff <= uart_engine_pkg::RESET_BYTE;
            end else if (rise_tick) begin
                unique case (state_ff)
                    ST_IDLE: begin
                    end
                    ST_START: begin
                        state_ff <= rx_level ? ST_IDLE : ST_DATA;
                    end
                    ST_DATA: begin
                        shift_ff <= frame_format_config_ff[uart_engine_pkg::FMT_MSB_BIT]
                            ? {shift_ff[6:0], rx_level} : {rx_level, shift_ff[7:1]};
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == last_bit) begin
                            state_ff <= frame_format_config_ff[uart_engine_pkg::FMT_PAR_EN_BIT]
                                ? ST_PARITY : ST_STOP;
                        end
                    end
                    ST_PARITY: begin
                        rx_parity_ff <= rx_level;
                        state_ff <= ST_STOP;
                    end
                    ST_STOP: begin
                        rx_done_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign serial_out_pin = transmit_mode ? serial_out_ff
        ^ frame_format_config_ff[uart_engine_pkg::FMT_NEG_BIT] : 1'b1;

    // Start-bit and end-of-transmit interrupts; receive at stop check
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= buf_load
                || (transmit_mode && run_bit_ff && fall_tick && state_ff == ST_STOP
                && stop_cnt_ff && !buffer_full_flag_ff)
                || (!transmit_mode && rx_done_ff);
        end
    end
    assign channel_irq = irq_ff;

    // Run bit: software sets/clears; transmitter clears at end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            run_bit_ff <= 1'b0;
            run_prev_ff <= 1'b0;
        end else begin
            run_prev_ff <= run_bit_ff;
            if (reg_write && reg_addr == uart_engine_pkg::ADDR_CONTROL) begin
                run_bit_ff <= reg_wdata[uart_engine_pkg::CTRL_RUN_BIT];
            end else if (transmit_mode && run_bit_ff && fall_tick && state_ff == ST_STOP
                && stop_cnt_ff && !buffer_full_flag_ff) begin
                run_bit_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_config_zero_ff <= uart_engine_pkg::RESET_BYTE;
            frame_format_config_ff <= uart_engine_pkg::RESET_BYTE;
            baud_count_low_ff <= uart_engine_pkg::RESET_BYTE;
            baud_count_high_ff <= '0;
        end else if (reg_write) begin
            unique case (reg_addr)
                uart_engine_pkg::ADDR_MODE0: mode_config_zero_ff <= reg_wdata;
                uart_engine_pkg::ADDR_FORMAT: frame_format_config_ff <= reg_wdata;
                uart_engine_pkg::ADDR_BAUD_LOW: baud_count_low_ff <= reg_wdata;
                uart_engine_pkg::ADDR_BAUD_HIGH: baud_count_high_ff <= reg_wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // Received word lands the cycle after the stop-bit rise
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shared_data_buffer_ff <= uart_engine_pkg::RESET_BYTE;
            rx_unread_ff <= 1'b0;
        end else begin
            if (reg_write && reg_addr == uart_engine_pkg::ADDR_BUFFER) begin
                shared_data_buffer_ff <= reg_wdata;
            end else if (rx_done_ff && !transmit_mode) begin
                shared_data_buffer_ff <= rx_word;
            end
            if (rx_done_ff && !transmit_mode) begin
                rx_unread_ff <= 1'b1;
            end else if (reg_read && reg_addr == uart_engine_pkg::ADDR_BUFFER) begin
                rx_unread_ff <= 1'b0;
            end
        end
    end

    // Status flags: hardware set beats software clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            buffer_full_flag_ff <= 1'b0;
            parity_error_flag_ff <= 1'b0;
            overrun_error_flag_ff <= 1'b0;
            framing_error_flag_ff <= 1'b0;
        end else begin
            if (transmit_mode && reg_write && reg_addr == uart_engine_pkg::ADDR_BUFFER) begin
                buffer_full_flag_ff <= 1'b1;
            end else if (buf_load || stat_clear || !transmit_mode) begin
                buffer_full_flag_ff <= 1'b0;
            end
            if (rx_done_ff && !transmit_mode) begin
                parity_error_flag_ff <= frame_format_config_ff[uart_engine_pkg::FMT_PAR_EN_BIT]
                    && (rx_parity_ff != rx_calc_parity);
                framing_error_flag_ff <= !rx_level;
                overrun_error_flag_ff <= overrun_error_flag_ff || rx_unread_ff;
            end else if (stat_clear || transmit_mode) begin
                parity_error_flag_ff <= 1'b0;
                framing_error_flag_ff <= 1'b0;
                overrun_error_flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata_ff <= uart_engine_pkg::RESET_BYTE;
        end else begin
            unique case (reg_addr)
                uart_engine_pkg::ADDR_MODE0: reg_rdata_ff <= mode_config_zero_ff;
                uart_engine_pkg::ADDR_FORMAT: reg_rdata_ff <= frame_format_config_ff;
                uart_engine_pkg::ADDR_BAUD_LOW: reg_rdata_ff <= baud_count_low_ff;
                uart_engine_pkg::ADDR_BAUD_HIGH: reg_rdata_ff <= {4'h0, baud_count_high_ff};
                uart_engine_pkg::ADDR_CONTROL: reg_rdata_ff <= {7'h00, run_bit_ff};
                uart_engine_pkg::ADDR_BUFFER: reg_rdata_ff <= shared_data_buffer_ff;
                uart_engine_pkg::ADDR_STATUS: reg_rdata_ff <= {4'h0, buffer_full_flag_ff,
                    parity_error_flag_ff, overrun_error_flag_ff, framing_error_flag_ff};
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = reg_rdata_ff;
endmodule // uart_tx_rx_engine

// ==== uart_tx_rx_engine_test.sv ====
`timescale 1ns/100ps
module uart_tx_rx_engine_test;
    localparam logic [2:0] MD = uart_engine_pkg::ADDR_MODE0;
    localparam logic [2:0] FM = uart_engine_pkg::ADDR_FORMAT;
    localparam logic [2:0] CT = uart_engine_pkg::ADDR_CONTROL;
    localparam logic [2:0] BF = uart_engine_pkg::ADDR_BUFFER;
    localparam logic [2:0] ST = uart_engine_pkg::ADDR_STATUS;
    logic ref_clk;
    logic reset;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic [3:0] source_ticks;
    logic serial_in_pin_b;
    logic serial_out_pin;
    logic channel_irq;
    int fails;
    int comparisons;
    uart_tx_rx_engine dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .source_ticks(source_ticks), .serial_in_pin_a(1'b0),
        .serial_in_pin_b(serial_in_pin_b), .serial_out_pin(serial_out_pin),
        .channel_irq(channel_irq));
    uart_peer_model peer_u (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin),
        .serial_in_pin_b(serial_in_pin_b));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Source clock at half rate: one tick every two cycles, 16 cycles a bit
    always @(posedge ref_clk) source_ticks <= ~source_ticks;
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 check(name, exp, reg_rdata);
    endtask
    task automatic wait_irq(input string name);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 400 && !seen; i++) begin
            @(posedge ref_clk);
            seen = (channel_irq === 1'b1);
        end
        check(name, 8'h01, {7'h0, seen});
    endtask
    task automatic rx_frame(input logic [7:0] d, input logic p, input logic s);
        fork
            peer_u.send(d, p, s);
            wait_irq("rx irq");
        join
    endtask
    task automatic t_reset;
        rd_chk("status", ST, 8'h00);
        rd_chk("control", CT, 8'h00);
        rd_chk("unmapped", 3'h7, 8'h00);
        check("idle out", 8'h01, {7'h0, serial_out_pin});
        $display("test reset done");
    endtask
    task automatic t_tx;
        wr(FM, 8'h03);
        wr(uart_engine_pkg::ADDR_BAUD_LOW, 8'h07);
        wr(uart_engine_pkg::ADDR_BAUD_HIGH, 8'h00);
        wr(MD, 8'h00);
        wr(BF, 8'ha5);
        rd_chk("full", ST, 8'h08);
        wr(CT, 8'h01);
        wait_irq("start irq");
        check("start bit", 8'h00, {7'h0, serial_out_pin});
        wr(BF, 8'h3c);
        rd_chk("full again", ST, 8'h08);
        wait_irq("next irq");
        wait_irq("end irq");
        rd_chk("run cleared", CT, 8'h00);
        rd_chk("full clear", ST, 8'h00);
        repeat (20) @(posedge ref_clk);
        check("frames", 8'h02, 8'(peer_u.got_q.size()));
        check("byte 0", 8'ha5, peer_u.got_q[0]);
        check("byte 1", 8'h3c, peer_u.got_q[1]);
        $display("test transmit done");
    endtask
    task automatic t_rx;
        wr(FM, 8'h07);
        wr(MD, 8'h11);
        wr(CT, 8'h01);
        rx_frame(8'h5a, 1'b0, 1'b1);
        rd_chk("rx byte", BF, 8'h5a);
        rd_chk("rx clean", ST, 8'h00);
        rx_frame(8'h81, 1'b1, 1'b1);
        rd_chk("parity err", ST, 8'h04);
        rx_frame(8'h33, 1'b0, 1'b0);
        rd_chk("overrun framing", ST, 8'h03);
        wr(ST, 8'h00);
        rd_chk("cleared", ST, 8'h00);
        rd_chk("last byte", BF, 8'h33);
        wr(FM, 8'h0f);
        rx_frame(8'h01, 1'b0, 1'b1);
        rd_chk("odd byte", BF, 8'h01);
        rd_chk("odd clean", ST, 8'h00);
        wr(FM, 8'h23);
        rx_frame(8'h01, 1'b1, 1'b1);
        rd_chk("msb first", BF, 8'h80);
        $display("test receive done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        fails = 0;
        comparisons = 0;
        reset = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        source_ticks = 4'h0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("FAIL watchdog expected done seen hang");
        wrap_up();
    end
endmodule // uart_tx_rx_engine_test
